// ==== shared/dtc_regs.svh ====
// Constants for the trouble code manager: timing, field positions, resets.
// Assumes a single system clock; times are given in their own units.
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_CLK_NS 50
`define DTC_MS_NS 1000000
`define DTC_DM1_PERIOD_MS 1000
`define DTC_STARTUP_MS 5000
`define DTC_GLOBAL_SA 8'hFF
`define DTC_OC_MAX 7'h7F
`define DTC_OC_RST 7'h00
`define DTC_LAMP_ON 2'h1
`define DTC_SPN_LO_LSB 0
`define DTC_FMI_LSB 16
`define DTC_SPN_HI_LSB 21
`define DTC_OC_LSB 24
`define DTC_CM_BIT 31
`define DTC_CM_VAL 1'b0

`endif

// ==== shared/dtc_pkg.sv ====
// Types shared by the trouble code manager and its surroundings.
// Assumes the includer also pulls in dtc_regs.svh for constants.
package dtc_pkg;

  typedef enum logic [3:0] {
    DTC_RQ_DM1 = 4'h1,
    DTC_RQ_DM2 = 4'h2,
    DTC_RQ_DM3 = 4'h4,
    DTC_RQ_DM11 = 4'h8
  } dtc_req_e;

  typedef enum logic [2:0] {
    DTC_MODE_SINGLE = 3'h1,
    DTC_MODE_BAM = 3'h2,
    DTC_MODE_TP = 3'h4
  } dtc_mode_e;

  typedef enum logic [1:0] {
    DTC_MSG_DM1 = 2'h1,
    DTC_MSG_DM2 = 2'h2
  } dtc_msg_e;

  typedef enum logic [1:0] {
    DTC_ST_HOLD = 2'h1,
    DTC_ST_RUN = 2'h2
  } dtc_state_e;

  typedef enum logic [1:0] {
    DTC_LAMP_PROTECT = 2'h0,
    DTC_LAMP_AMBER = 2'h1,
    DTC_LAMP_RED = 2'h2,
    DTC_LAMP_MIL = 2'h3
  } dtc_lamp_e;

  typedef struct packed {
    logic in_dm1;
    logic clr_dm11;
    dtc_lamp_e lamp;
    logic [18:0] spn;
    logic [4:0] fmi;
    logic [15:0] delay_ms;
  } dtc_blk_cfg_s;

  typedef struct packed {
    logic en;
    logic pdu1;
    logic [7:0] src_sa;
    logic [15:0] timeout_ms;
  } dtc_rx_cfg_s;

  typedef struct packed {
    dtc_msg_e msg;
    dtc_mode_e mode;
    logic [7:0] dest;
    logic [7:0] lamp;
    logic [7:0] ndtc;
  } dtc_tx_s;

endpackage

// ==== logic/dtc_manager.sv ====
// Trouble code manager: fault qualification, counts, DM1 scheduling,
// DM2/DM3/DM11 handling and receive timeouts.
// Assumes a transmit engine that takes one descriptor per tx_valid_r
// pulse and reads trouble codes through dtc_sel / dtc_word_r.
//
// Summary of operation
// - With any block reporting into DM1, send DM1 every second.
// - With nothing active, the periodic DM1 carries no-active-faults.
// - Inactive to active code sends a DM1 at once.
// - Last active code going inactive sends a DM1 at once.
// - Two or more active codes: periodic DM1 goes as BAM.
// - DM1 request with two or more active: TP to requester.
// - No DM1 broadcast during the first five seconds.
// - Fault must persist through the send delay before activating.
// - Counts are non-volatile; saves wait until the motor stops.
// - DM2 reports nonzero counts; several go TP to requester.
// - DM3 zeroes counts of inactive codes, active ones kept.
// - Option off: code drops from DM1 as its fault clears.
// - Option on: code stays active until a DM11 request.
// - First DM1 byte is lamp status from active blocks' lamps.
// - Changing a block's parameter number zeroes its counts.
// - Changing a block's low failure mode zeroes its counts.
// - High failure mode derived from low by fixed pairs.
// - Unpaired low mode reused for high; counts stay separate.
// - Code packs 19-bit number, 5-bit mode, 7-bit count, zero bit.
// - Enabled message missing past timeout raises lost-comm fault.
// - Zero timeout disables monitoring of that message.
// - PDU1 filter 0xFF takes any sender, else only that one.
`timescale 1ns/1ps
`include "dtc_regs.svh"

module dtc_manager import dtc_pkg::*; #(
  parameter int NFB = 4,
  parameter int NRX = 15,
  parameter int MS_CYCLES = `DTC_MS_NS / `DTC_CLK_NS,
  parameter int DM1_PERIOD_MS = `DTC_DM1_PERIOD_MS,
  parameter int STARTUP_MS = `DTC_STARTUP_MS,
  parameter int NE = 2 * NFB,
  parameter int IW = $clog2(NE)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire dtc_blk_cfg_s cfg_blk [NFB],
  input wire logic [NFB-1:0] fault_lo,
  input wire logic [NFB-1:0] fault_hi,
  input wire logic motor_running,
  input wire logic req_valid,
  input wire dtc_req_e req_kind,
  input wire logic [7:0] req_sa,
  input wire dtc_rx_cfg_s cfg_rx [NRX],
  input wire logic rx_valid,
  input wire logic [3:0] rx_idx,
  input wire logic [7:0] rx_sa,
  input wire logic nvm_ld_valid,
  input wire logic [IW-1:0] nvm_ld_idx,
  input wire logic [6:0] nvm_ld_oc,
  input wire logic [IW-1:0] dtc_sel,
  output logic [31:0] dtc_word_r,
  output logic tx_valid_r,
  output dtc_tx_s tx_r,
  output logic [NE-1:0] act_r,
  output logic [NRX-1:0] rx_lost_r,
  output logic lost_comm_r,
  output logic nvm_wr_r,
  output logic [IW-1:0] nvm_idx_r,
  output logic [6:0] nvm_oc_r
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] fmi_high(input logic [4:0] lo);
    case (lo)
      5'h01: fmi_high = 5'h00;
      5'h04: fmi_high = 5'h03;
      5'h05: fmi_high = 5'h06;
      5'h11: fmi_high = 5'h0F;
      5'h12: fmi_high = 5'h10;
      5'h15: fmi_high = 5'h14;
      default: fmi_high = lo;
    endcase
  endfunction

  function automatic logic [7:0] count_set(input logic [NE-1:0] v);
    count_set = 8'h00;
    for (int k = 0; k < NE; k++) begin
      count_set = count_set + {7'h00, v[k]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Fault entries: even index is the low fault, odd the high fault
  logic [6:0] oc_r [NE];
  logic [6:0] oc_nxt [NE];
  logic [15:0] tmr_r [NE];
  logic [15:0] tmr_nxt [NE];
  logic [NE-1:0] act_nxt, dirty_r, dirty_nxt, ocnz_c;
  logic [23:0] prev_r [NFB];
  logic [23:0] prev_nxt [NFB];
  logic primed_r, primed_nxt, rise_c, nvm_take_c;
  logic [IW-1:0] nvm_pick_c;
  logic ms_tick_r, dm3_c, dm11_c;

  assign dm3_c = req_valid && req_kind == DTC_RQ_DM3;
  assign dm11_c = req_valid && req_kind == DTC_RQ_DM11;

  always_comb begin
    logic cond;
    logic chg;
    cond = 1'b0;
    chg = 1'b0;
    act_nxt = act_r;
    dirty_nxt = dirty_r;
    rise_c = 1'b0;
    primed_nxt = 1'b1;
    if (nvm_take_c) begin
      dirty_nxt[nvm_pick_c] = 1'b0;
    end
    for (int b = 0; b < NFB; b++) begin
      prev_nxt[b] = {cfg_blk[b].spn, cfg_blk[b].fmi};
    end
    for (int i = 0; i < NE; i++) begin
      oc_nxt[i] = oc_r[i];
      tmr_nxt[i] = tmr_r[i];
      cond = i[0] ? fault_hi[i/2] : fault_lo[i/2];
      chg = primed_r && prev_r[i/2] != prev_nxt[i/2];
      if (!cfg_blk[i/2].in_dm1) begin
        act_nxt[i] = 1'b0;
        tmr_nxt[i] = 16'h0000;
      end else if (!act_r[i]) begin
        if (!cond) begin
          tmr_nxt[i] = 16'h0000;
        end else if (tmr_r[i] >= cfg_blk[i/2].delay_ms) begin
          act_nxt[i] = 1'b1;
          rise_c = 1'b1;
          tmr_nxt[i] = 16'h0000;
          dirty_nxt[i] = 1'b1;
          if (oc_r[i] != `DTC_OC_MAX) begin
            oc_nxt[i] = oc_r[i] + 7'h01;
          end
        end else if (ms_tick_r) begin
          tmr_nxt[i] = tmr_r[i] + 16'h0001;
        end
      end else if ((!cond && !cfg_blk[i/2].clr_dm11) || dm11_c) begin
        act_nxt[i] = 1'b0;
      end
      if (dm3_c && !act_r[i] && !act_nxt[i]) begin
        oc_nxt[i] = `DTC_OC_RST;
        dirty_nxt[i] = 1'b1;
      end
      if (chg) begin
        oc_nxt[i] = `DTC_OC_RST;
        dirty_nxt[i] = 1'b1;
      end
      if (nvm_ld_valid && nvm_ld_idx == i[IW-1:0]) begin
        oc_nxt[i] = nvm_ld_oc;
      end
      ocnz_c[i] = oc_r[i] != `DTC_OC_RST;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      act_r <= '0;
      dirty_r <= '0;
      primed_r <= 1'b0;
      for (int i = 0; i < NE; i++) begin
        oc_r[i] <= `DTC_OC_RST;
        tmr_r[i] <= 16'h0000;
      end
      for (int b = 0; b < NFB; b++) begin
        prev_r[b] <= 24'h000000;
      end
    end else begin
      act_r <= act_nxt;
      dirty_r <= dirty_nxt;
      primed_r <= primed_nxt;
      oc_r <= oc_nxt;
      tmr_r <= tmr_nxt;
      prev_r <= prev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Non-volatile saves drain one count per cycle while the motor is idle
  logic nvm_wr_nxt;
  logic [IW-1:0] nvm_idx_nxt;
  logic [6:0] nvm_oc_nxt;

  always_comb begin
    nvm_pick_c = '0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (dirty_r[i]) begin
        nvm_pick_c = i[IW-1:0];
      end
    end
    nvm_take_c = |dirty_r && !motor_running;
    nvm_wr_nxt = nvm_take_c;
    nvm_idx_nxt = nvm_take_c ? nvm_pick_c : nvm_idx_r;
    nvm_oc_nxt = nvm_take_c ? oc_r[nvm_pick_c] : nvm_oc_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nvm_wr_r <= 1'b0;
      nvm_idx_r <= '0;
      nvm_oc_r <= `DTC_OC_RST;
    end else begin
      nvm_wr_r <= nvm_wr_nxt;
      nvm_idx_r <= nvm_idx_nxt;
      nvm_oc_r <= nvm_oc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base, start-up hold and DM1 scheduling
  dtc_state_e st_r, st_nxt;
  logic [15:0] ms_cnt_r, ms_cnt_nxt, per_r, per_nxt;
  logic ms_tick_nxt, pend_bc_r, pend_bc_nxt, pend_rq_r, pend_rq_nxt;
  logic bc_fire_c, tx_valid_nxt;
  dtc_msg_e rq_msg_r, rq_msg_nxt;
  logic [7:0] rq_sa_r, rq_sa_nxt, nact_c, lamp_c, nprev_c;
  logic [31:0] dtc_word_nxt;
  dtc_tx_s tx_nxt;

  always_comb begin
    logic any_dm1;
    any_dm1 = 1'b0;
    lamp_c = 8'h00;
    for (int b = 0; b < NFB; b++) begin
      any_dm1 = any_dm1 | cfg_blk[b].in_dm1;
      if (act_r[2*b] || act_r[2*b+1]) begin
        lamp_c = lamp_c | (8'({`DTC_LAMP_ON}) << {cfg_blk[b].lamp, 1'b0});
      end
    end
    nact_c = count_set(act_r);
    nprev_c = count_set(ocnz_c);
    ms_tick_nxt = ms_cnt_r == 16'(MS_CYCLES - 1);
    ms_cnt_nxt = ms_tick_nxt ? 16'h0000 : ms_cnt_r + 16'h0001;
    st_nxt = st_r;
    per_nxt = per_r;
    bc_fire_c = 1'b0;
    case (st_r)
      DTC_ST_HOLD: begin
        if (ms_tick_r) begin
          per_nxt = per_r + 16'h0001;
        end
        if (per_r >= 16'(STARTUP_MS)) begin
          st_nxt = DTC_ST_RUN;
          per_nxt = 16'h0000;
        end
      end
      DTC_ST_RUN: begin
        if (ms_tick_r) begin
          per_nxt = (per_r >= 16'(DM1_PERIOD_MS - 1)) ? 16'h0000
                                                      : per_r + 16'h0001;
        end
        bc_fire_c = (ms_tick_r && per_r >= 16'(DM1_PERIOD_MS - 1) &&
                     any_dm1)
                    || rise_c
                    || (nact_c != 8'h00 && act_nxt == '0);
      end
      default: st_nxt = DTC_ST_HOLD;
    endcase
    rq_msg_nxt = rq_msg_r;
    rq_sa_nxt = rq_sa_r;
    pend_rq_nxt = pend_rq_r;
    pend_bc_nxt = pend_bc_r;
    tx_valid_nxt = 1'b0;
    tx_nxt = tx_r;
    if (pend_bc_r) begin
      tx_valid_nxt = 1'b1;
      pend_bc_nxt = 1'b0;
      tx_nxt.msg = DTC_MSG_DM1;
      tx_nxt.dest = `DTC_GLOBAL_SA;
      tx_nxt.ndtc = nact_c;
      tx_nxt.mode = nact_c >= 8'h02 ? DTC_MODE_BAM
                                    : DTC_MODE_SINGLE;
      tx_nxt.lamp = lamp_c;
    end else if (pend_rq_r) begin
      tx_valid_nxt = 1'b1;
      pend_rq_nxt = 1'b0;
      tx_nxt.msg = rq_msg_r;
      tx_nxt.dest = rq_sa_r;
      tx_nxt.lamp = lamp_c;
      if (rq_msg_r == DTC_MSG_DM1) begin
        tx_nxt.ndtc = nact_c;
        tx_nxt.mode = nact_c >= 8'h02 ? DTC_MODE_TP
                                      : DTC_MODE_SINGLE;
      end else begin
        tx_nxt.ndtc = nprev_c;
        tx_nxt.mode = nprev_c > 8'h01 ? DTC_MODE_TP
                                      : DTC_MODE_SINGLE;
      end
    end
    // New events win over the service that clears the pending flags
    if (bc_fire_c) begin
      pend_bc_nxt = 1'b1;
    end
    if (req_valid && (req_kind == DTC_RQ_DM1 || req_kind == DTC_RQ_DM2)) begin
      pend_rq_nxt = 1'b1;
      rq_sa_nxt = req_sa;
      rq_msg_nxt = req_kind == DTC_RQ_DM1 ? DTC_MSG_DM1 : DTC_MSG_DM2;
    end
    dtc_word_nxt = '0;
    dtc_word_nxt[`DTC_SPN_LO_LSB +: 16] = cfg_blk[dtc_sel/2].spn[15:0];
    dtc_word_nxt[`DTC_FMI_LSB +: 5] = dtc_sel[0]
                                      ? fmi_high(cfg_blk[dtc_sel/2].fmi)
                                      : cfg_blk[dtc_sel/2].fmi;
    dtc_word_nxt[`DTC_SPN_HI_LSB +: 3] = cfg_blk[dtc_sel/2].spn[18:16];
    dtc_word_nxt[`DTC_OC_LSB +: 7] = oc_r[dtc_sel];
    dtc_word_nxt[`DTC_CM_BIT] = `DTC_CM_VAL;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= DTC_ST_HOLD;
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
      per_r <= 16'h0000;
      pend_bc_r <= 1'b0;
      pend_rq_r <= 1'b0;
      rq_msg_r <= DTC_MSG_DM1;
      rq_sa_r <= `DTC_GLOBAL_SA;
      tx_valid_r <= 1'b0;
      tx_r <= '{DTC_MSG_DM1, DTC_MODE_SINGLE, 8'hFF, 8'h00, 8'h00};
      dtc_word_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      ms_tick_r <= ms_tick_nxt;
      per_r <= per_nxt;
      pend_bc_r <= pend_bc_nxt;
      pend_rq_r <= pend_rq_nxt;
      rq_msg_r <= rq_msg_nxt;
      rq_sa_r <= rq_sa_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_r <= tx_nxt;
      dtc_word_r <= dtc_word_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive timeouts; counters restart on every accepted frame
  logic [15:0] rx_cnt_r [NRX];
  logic [15:0] rx_cnt_nxt [NRX];
  logic [NRX-1:0] rx_lost_nxt;
  logic [NRX-1:0] tmo_zero_c;

  always_comb begin
    logic acc;
    acc = 1'b0;
    for (int j = 0; j < NRX; j++) begin
      acc = rx_valid && rx_idx == j[3:0] && (!cfg_rx[j].pdu1 ||
            cfg_rx[j].src_sa == `DTC_GLOBAL_SA ||
            cfg_rx[j].src_sa == rx_sa);
      rx_cnt_nxt[j] = rx_cnt_r[j];
      tmo_zero_c[j] = cfg_rx[j].timeout_ms == 16'h0000;
      if (!cfg_rx[j].en || cfg_rx[j].timeout_ms == 16'h0000 || acc) begin
        rx_cnt_nxt[j] = 16'h0000;
      end else if (ms_tick_r && rx_cnt_r[j] < cfg_rx[j].timeout_ms) begin
        rx_cnt_nxt[j] = rx_cnt_r[j] + 16'h0001;
      end
      rx_lost_nxt[j] = cfg_rx[j].en && cfg_rx[j].timeout_ms != 16'h0000 &&
                       rx_cnt_nxt[j] >= cfg_rx[j].timeout_ms;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_lost_r <= '0;
      lost_comm_r <= 1'b0;
      for (int j = 0; j < NRX; j++) begin
        rx_cnt_r[j] <= 16'h0000;
      end
    end else begin
      rx_lost_r <= rx_lost_nxt;
      lost_comm_r <= |rx_lost_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  hold_dm1_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_r == DTC_ST_HOLD |-> !pend_bc_r) else $error("DM1 queued in hold");
  period_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_r == DTC_ST_RUN && ms_tick_r && per_r == 16'(DM1_PERIOD_MS - 1) &&
    cfg_blk[0].in_dm1 |-> ##2 tx_valid_r && tx_r.dest == `DTC_GLOBAL_SA)
    else $error("periodic DM1 missing");
  rise_send_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_r == DTC_ST_RUN && rise_c |=> pend_bc_r)
    else $error("activation without DM1");
  bam_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_valid_r && tx_r.msg == DTC_MSG_DM1 && tx_r.dest == `DTC_GLOBAL_SA &&
    tx_r.ndtc >= 8'h02 |-> tx_r.mode == DTC_MODE_BAM)
    else $error("multi-code DM1 not BAM");
  single_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_valid_r && tx_r.msg == DTC_MSG_DM1 && tx_r.ndtc < 8'h02
    |-> tx_r.mode == DTC_MODE_SINGLE) else $error("short DM1 not single");
  rq_tp_a: assert property (@(posedge clk) disable iff (!reset_n)
    req_valid && req_kind == DTC_RQ_DM1 && !pend_bc_r && !bc_fire_c &&
    nact_c >= 8'h02 && act_nxt == act_r |=> ##1 tx_valid_r &&
    tx_r.mode == DTC_MODE_TP && tx_r.dest == $past(req_sa, 2))
    else $error("DM1 request not TP");
  dm3_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    dm3_c && !act_r[0] && !nvm_ld_valid |=> oc_r[0] == `DTC_OC_RST || act_r[0])
    else $error("DM3 left count");
  nvm_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    nvm_wr_r |-> $past(!motor_running)) else $error("save while running");
  tmo_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_lost_r & $past(tmo_zero_c)) == '0) else $error("zero timeout lost");

endmodule // dtc_manager

// ==== testbench/dtc_peer.sv ====
// Other bus nodes: feed receive frames, log every outgoing descriptor.
// Assumes one clock; slots 0 and 1 get a frame every 2 ms each.
`timescale 1ns/1ps

module dtc_peer import dtc_pkg::*; #(
  parameter int MS_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sa0,
  input wire logic tx_valid_r,
  input wire dtc_tx_s tx_r,
  output logic rx_valid,
  output logic [3:0] rx_idx,
  output logic [7:0] rx_sa,
  output int n_tx,
  output dtc_tx_s last_tx
);
  int cnt;
  initial n_tx = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Update period of 2 ms per slot, a third of the 6 ms timeout
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      rx_valid <= 1'b0;
      rx_idx <= 4'hF;
      rx_sa <= 8'h00;
    end else begin
      cnt <= cnt + 1;
      rx_valid <= 1'b0;
      // Idle lines toggle so stale values never look valid
      rx_sa <= ~rx_sa;
      rx_idx <= ~rx_idx;
      if (cnt % MS_CYCLES == 0) begin
        rx_valid <= 1'b1;
        rx_idx <= 4'((cnt / MS_CYCLES) % 2);
        rx_sa <= ((cnt / MS_CYCLES) % 2 == 1) ? 8'h55 : sa0;
      end
    end
  end

  always @(posedge clk) begin
    if (tx_valid_r === 1'b1) begin
      n_tx <= n_tx + 1;
      last_tx <= tx_r;
    end
  end
endmodule // dtc_peer

// ==== testbench/tb_diagnostic_dtc_manager.sv ====
// Self-checking bench for the trouble code manager.
// Assumes dtc_pkg is compiled first; short ms and period for speed.
`timescale 1ns/1ps

module tb_diagnostic_dtc_manager import dtc_pkg::*;;
  localparam int NFB = 2;
  localparam int NRX = 15;
  typedef struct packed {
    logic [4:0] lo;
    logic [4:0] hi;
    logic [18:0] spn;
  } dtc_row_s;
  dtc_row_s rows [7] = '{'{5'h01, 5'h00, 19'h1ABCD}, '{5'h04, 5'h03, 19'h00001},
    '{5'h05, 5'h06, 19'h40000}, '{5'h11, 5'h0F, 19'h7FFFF},
    '{5'h12, 5'h10, 19'h2F00F}, '{5'h15, 5'h14, 19'h10203},
    '{5'h07, 5'h07, 19'h0C0DE}};
  logic clk, reset_n, motor_running, req_valid, nvm_ld_valid;
  logic rx_valid, tx_valid_r, lost_comm_r, nvm_wr_r;
  dtc_blk_cfg_s cfg_blk [NFB];
  dtc_rx_cfg_s cfg_rx [NRX];
  logic [NFB-1:0] fault_lo, fault_hi;
  dtc_req_e req_kind;
  logic [7:0] req_sa, rx_sa, sa0;
  logic [3:0] rx_idx, act_r;
  logic [1:0] nvm_ld_idx, dtc_sel, nvm_idx_r;
  logic [6:0] nvm_ld_oc, nvm_oc_r;
  logic [31:0] dtc_word_r;
  logic [NRX-1:0] rx_lost_r;
  dtc_tx_s tx_r, last_tx;
  int n_tx, n_fail, checks, n_nvm_run, n_nvm, n_seen;
  logic [8:0] nvm_last;
  time t0;

  dtc_manager #(.NFB(NFB), .NRX(NRX), .MS_CYCLES(4), .DM1_PERIOD_MS(5),
    .STARTUP_MS(3)) i_dtc_manager (.clk(clk), .reset_n(reset_n),
    .cfg_blk(cfg_blk), .fault_lo(fault_lo), .fault_hi(fault_hi),
    .motor_running(motor_running), .req_valid(req_valid),
    .req_kind(req_kind), .req_sa(req_sa), .cfg_rx(cfg_rx),
    .rx_valid(rx_valid), .rx_idx(rx_idx), .rx_sa(rx_sa),
    .nvm_ld_valid(nvm_ld_valid), .nvm_ld_idx(nvm_ld_idx),
    .nvm_ld_oc(nvm_ld_oc), .dtc_sel(dtc_sel), .dtc_word_r(dtc_word_r),
    .tx_valid_r(tx_valid_r), .tx_r(tx_r), .act_r(act_r),
    .rx_lost_r(rx_lost_r), .lost_comm_r(lost_comm_r), .nvm_wr_r(nvm_wr_r),
    .nvm_idx_r(nvm_idx_r), .nvm_oc_r(nvm_oc_r));

  dtc_peer #(.MS_CYCLES(4)) i_dtc_peer (.clk(clk), .reset_n(reset_n),
    .sa0(sa0), .tx_valid_r(tx_valid_r), .tx_r(tx_r), .rx_valid(rx_valid),
    .rx_idx(rx_idx), .rx_sa(rx_sa), .n_tx(n_tx), .last_tx(last_tx));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (nvm_wr_r === 1'b1) begin
      n_nvm++;
      nvm_last = {nvm_idx_r, nvm_oc_r};
      if (motor_running) n_nvm_run++;
    end
  end

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic bad(input string what);
    n_fail++;
    $display("BAD %0t %s", $time, what);
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    checks++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic chk_tx(input dtc_msg_e m, input dtc_mode_e md,
                        input logic [7:0] lamp, input logic [7:0] n);
    checks++;
    if (last_tx.msg !== m || last_tx.mode !== md || last_tx.lamp !== lamp ||
        last_tx.ndtc !== n) bad($sformatf("descriptor %h", last_tx));
  endtask

  // Stimulus always lands 5 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic wait_tx(input logic [7:0] dest, input logic [7:0] n,
                         input int max);
    int seen;
    seen = n_tx;
    for (int i = 0; i < max; i++) begin
      cyc(1);
      if (n_tx != seen && last_tx.dest === dest && last_tx.ndtc === n) return;
      seen = n_tx;
    end
    bad($sformatf("no message to %h with %0d codes", dest, n));
  endtask

  task automatic wait_act(input logic [3:0] exp);
    for (int i = 0; i < 30; i++) begin
      if (act_r === exp) return;
      cyc(1);
    end
    bad("active set not reached");
  endtask

  task automatic req(input dtc_req_e k, input logic [7:0] sa);
    req_kind = k;
    req_sa = sa;
    req_valid = 1'b1;
    cyc(1);
    req_valid = 1'b0;
  endtask

  task automatic code_oc(input logic [1:0] sel, input logic [6:0] exp);
    dtc_sel = sel;
    cyc(2);
    chk_val(dtc_word_r[30:24], exp, "count");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    motor_running = 1'b1;
    req_valid = 1'b0;
    req_kind = DTC_RQ_DM1;
    req_sa = 8'h00;
    nvm_ld_valid = 1'b0;
    nvm_ld_idx = 2'h0;
    nvm_ld_oc = 7'h00;
    dtc_sel = 2'h0;
    fault_lo = '0;
    fault_hi = '0;
    sa0 = 8'h21;
    cfg_blk[0] = '{1'b1, 1'b0, DTC_LAMP_AMBER, 19'h12345, 5'h01, 16'h0002};
    cfg_blk[1] = '{1'b1, 1'b0, DTC_LAMP_RED, 19'h00321, 5'h04, 16'h0000};
    foreach (cfg_rx[i]) cfg_rx[i] = '{1'b0, 1'b0, 8'hFF, 16'h0000};
    cfg_rx[0] = '{1'b1, 1'b1, 8'h21, 16'h0006};
    cfg_rx[1] = '{1'b1, 1'b1, 8'hFF, 16'h0006};
    cfg_rx[2] = '{1'b1, 1'b0, 8'hFF, 16'h0000};
    repeat (5) @(posedge clk);
    #5 reset_n = 1'b1;
    cyc(9);
    chk_val(n_tx, 0, "early broadcast");
    wait_tx(8'hFF, 8'h00, 30);
    chk_tx(DTC_MSG_DM1, DTC_MODE_SINGLE, 8'h00, 8'h00);
    t0 = $time;
    wait_tx(8'hFF, 8'h00, 30);
    chk_val(32'($time - t0), 32'd1000, "period");
    $display("test periodic done");
    for (int i = 0; i < 7; i++) begin
      cfg_blk[0].fmi = rows[i].lo;
      cfg_blk[0].spn = rows[i].spn;
      dtc_sel = 2'h0;
      cyc(3);
      chk_val(dtc_word_r, {8'h00, rows[i].spn[18:16], rows[i].lo,
        rows[i].spn[15:0]}, "low code");
      dtc_sel = 2'h1;
      cyc(2);
      chk_val(dtc_word_r, {8'h00, rows[i].spn[18:16], rows[i].hi,
        rows[i].spn[15:0]}, "high code");
    end
    $display("test code table done");
    fault_lo[0] = 1'b1;
    cyc(2);
    chk_val(act_r, 4'h0, "early activation");
    wait_act(4'h1);
    wait_tx(8'hFF, 8'h01, 4);
    chk_tx(DTC_MSG_DM1, DTC_MODE_SINGLE, 8'h04, 8'h01);
    code_oc(2'h0, 7'h01);
    fault_hi[1] = 1'b1;
    wait_act(4'h9);
    wait_tx(8'hFF, 8'h02, 4);
    chk_tx(DTC_MSG_DM1, DTC_MODE_BAM, 8'h14, 8'h02);
    req(DTC_RQ_DM1, 8'h33);
    wait_tx(8'h33, 8'h02, 4);
    chk_tx(DTC_MSG_DM1, DTC_MODE_TP, 8'h14, 8'h02);
    fault_hi[1] = 1'b0;
    cyc(2);
    chk_val(act_r, 4'h1, "high cleared");
    fault_lo[0] = 1'b0;
    wait_tx(8'hFF, 8'h00, 4);
    chk_val(act_r, 4'h0, "low cleared");
    $display("test activation done");
    req(DTC_RQ_DM2, 8'h44);
    wait_tx(8'h44, 8'h02, 4);
    chk_tx(DTC_MSG_DM2, DTC_MODE_TP, 8'h00, 8'h02);
    cfg_blk[0].clr_dm11 = 1'b1;
    fault_lo[0] = 1'b1;
    wait_tx(8'hFF, 8'h01, 30);
    fault_lo[0] = 1'b0;
    cyc(10);
    chk_val(act_r, 4'h1, "latched code");
    req(DTC_RQ_DM11, 8'h33);
    wait_tx(8'hFF, 8'h00, 5);
    chk_val(act_r, 4'h0, "after clear");
    fault_hi[1] = 1'b1;
    wait_tx(8'hFF, 8'h01, 30);
    req(DTC_RQ_DM3, 8'h33);
    cyc(1);
    code_oc(2'h0, 7'h00);
    code_oc(2'h3, 7'h02);
    cfg_blk[1].spn = 19'h00400;
    cyc(2);
    code_oc(2'h3, 7'h00);
    nvm_ld_valid = 1'b1;
    nvm_ld_oc = 7'h05;
    cyc(1);
    nvm_ld_valid = 1'b0;
    code_oc(2'h0, 7'h05);
    cfg_blk[0].fmi = 5'h05;
    cyc(2);
    code_oc(2'h0, 7'h00);
    fault_hi[1] = 1'b0;
    $display("test requests done");
    chk_val(lost_comm_r, 1'b0, "frames kept alive");
    sa0 = 8'h22;
    for (int i = 0; i < 60 && rx_lost_r[0] !== 1'b1; i++) cyc(1);
    chk_val(rx_lost_r, 15'h0001, "foreign sender");
    chk_val(lost_comm_r, 1'b1, "lost comm");
    sa0 = 8'h21;
    cyc(12);
    chk_val(rx_lost_r, 15'h0000, "recovered");
    $display("test receive done");
    chk_val(n_nvm_run, 0, "save while running");
    motor_running = 1'b0;
    cyc(10);
    chk_val(n_nvm, 4, "save when stopped");
    $display("test storage done");
    fault_lo[0] = 1'b1;
    reset_n = 1'b0;
    cyc(1);
    chk_val({tx_valid_r, act_r, lost_comm_r}, 6'h00, "reset");
    chk_val(tx_r.dest, 8'hFF, "reset dest");
    n_seen = n_tx;
    reset_n = 1'b1;
    cyc(13);
    chk_val(act_r, 4'h1, "qualify in hold");
    chk_val(n_tx, n_seen, "hold after reset");
    chk_val(nvm_last, {2'h0, 7'h01}, "saved count");
    $display("test reset done");
    summarize();
  end

  initial begin
    #(4000 * 50);
    bad("watchdog");
    summarize();
  end
endmodule // tb_diagnostic_dtc_manager
